/* pkg/gpmc_pkg.sv */
// Package for the positioning-receiver operating-mode controller
package gpmc_pkg;
    // Register byte offsets
    localparam logic [7:0] GPMC_STATUS_OFS = 8'h00;
    localparam logic [7:0] GPMC_CONFIG_OFS = 8'h04;
    // Config field positions
    localparam int GPMC_RATE_LSB = 0;
    localparam int GPMC_SBAS_BIT = 4;
    localparam int GPMC_CANC_BIT = 5;
    localparam int GPMC_LOG_BIT = 6;
    localparam int GPMC_ORB_BIT = 7;
    localparam int GPMC_NMEA_LSB = 8;
    localparam int GPMC_BAUD_LSB = 14;
    // Power-up configuration: baud 9600, 1 Hz, SBAS, canceller, no logger, orbit assist
    localparam logic [3:0] GPMC_RATE_RST = 4'h1;
    localparam logic [5:0] GPMC_NMEA_RST = 6'h3F;
    localparam logic [17:0] GPMC_BAUD_RST = 18'h02580;
    localparam logic [31:0] GPMC_CONFIG_RST = {GPMC_BAUD_RST, GPMC_NMEA_RST, 4'hB, GPMC_RATE_RST};
    // Highest update rate that keeps orbit assist on
    localparam logic [3:0] GPMC_RATE_MAX_ORB = 4'h1;
    // Sentence characters
    localparam logic [7:0] GPMC_CH_START = 8'h24;
    localparam logic [7:0] GPMC_CH_STAR = 8'h2A;
    localparam logic [7:0] GPMC_CH_COMMA = 8'h2C;
    localparam logic [7:0] GPMC_CH_CR = 8'h0D;
    localparam logic [7:0] GPMC_CH_LF = 8'h0A;
    // Command codes and arguments
    localparam logic [9:0] GPMC_CMD_STBY = 10'h0A1;
    localparam logic [9:0] GPMC_CMD_PWR = 10'h0E1;
    localparam logic [9:0] GPMC_CMD_CONST = 10'h161;
    localparam logic [7:0] GPMC_ARG_FULL = 8'h00;
    localparam logic [7:0] GPMC_ARG_PBKP = 8'h01;
    localparam logic [7:0] GPMC_ARG_PSTBY = 8'h02;
    localparam logic [7:0] GPMC_ARG_BKP = 8'h04;
    localparam logic [7:0] GPMC_ARG_ASTBY = 8'h08;
    localparam logic [7:0] GPMC_ARG_ABKP = 8'h09;
    // Constellation argument patterns (arg1 in bit 4)
    localparam logic [4:0] GPMC_PAT_BOTH = 5'h11;
    localparam logic [4:0] GPMC_PAT_FIRST = 5'h10;
    localparam logic [4:0] GPMC_PAT_SECOND = 5'h01;
    // Operating modes
    typedef enum logic [2:0] {
        GPMC_ACQ, GPMC_TRK, GPMC_STBY, GPMC_BKP, GPMC_PER, GPMC_ADP
    } gpmc_mode_e;
endpackage : gpmc_pkg

/* rtl/gpmc_top.sv */
// Operating-mode controller: sentence parser, mode machine and AHB-Lite registers
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module gpmc_top
    import gpmc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Control pins from the host
    input wire logic stby_req_n,
    input wire logic force_on,
    // Received bytes from the host serial port receiver
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    // Navigation engine status
    input wire logic acq_done,
    // Power and engine controls
    output logic rf_pwr_en,
    output logic tcxo_en,
    output logic search_en,
    output logic nmea_en,
    output logic uart_en,
    output logic bkp_switch_open,
    output logic bkp_mem_hold,
    output logic hot_start,
    output logic [1:0] const_sel,
    output logic [2:0] mode,
    output logic lp_type_periodic_bkp,
    // Configuration outputs
    output logic [3:0] update_rate,
    output logic sbas_en,
    output logic canceller_en,
    output logic logger_en,
    output logic orbit_assist_en,
    output logic [5:0] nmea_mask,
    output logic [17:0] baud_rate
);

    // ==================================================================
    // Pin synchronisers
    // ==================================================================
    logic stby_meta_q, stby_sync_q, stby_last_q; // Request pin stages
    logic force_meta_q, force_sync_q; // Wake pin stages

    // Two stages per pin, then an edge history for the request pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stby_meta_q <= 1'b1;
            stby_sync_q <= 1'b1;
            stby_last_q <= 1'b1;
            force_meta_q <= 1'b0;
            force_sync_q <= 1'b0;
        end else begin
            stby_meta_q <= stby_req_n;
            stby_sync_q <= stby_meta_q;
            stby_last_q <= stby_sync_q;
            force_meta_q <= force_on;
            force_sync_q <= force_meta_q;
        end
    end

    logic stby_fall, stby_rise; // Edge-triggered request pin
    assign stby_fall = stby_last_q & ~stby_sync_q;
    assign stby_rise = ~stby_last_q & stby_sync_q;

    // ==================================================================
    // Sentence parser
    // ==================================================================
    gpmc_mode_e state_q, state_d; // Operating mode
    logic in_q, star_q; // Inside sentence, past checksum marker
    logic [7:0] sum_q, rxck_q; // Running and received checksum
    logic [1:0] nib_q; // Checksum digits seen
    logic [2:0] fld_q; // Field index, 0 is the header
    logic [9:0] code_q; // Command number from header
    logic [7:0] arg_q; // First argument value
    logic [4:0] pat_q; // Nonzero flags of arguments 1..5
    logic ok_q; // Pulse: accepted sentence
    logic is_dig, is_hex; // Character classes
    logic [3:0] dval, hval; // Digit values
    logic take; // Byte that the parser may use

    // Character decode
    always_comb begin
        is_dig = (rx_data >= 8'h30) && (rx_data <= 8'h39);
        dval = rx_data[3:0];
        is_hex = is_dig || ((rx_data >= 8'h41) && (rx_data <= 8'h46));
        hval = is_dig ? rx_data[3:0] : 4'(rx_data[3:0] + 4'h9);
    end

    // Bytes are dropped while in backup
    assign take = rx_valid && (state_q != GPMC_BKP);

    // Parser state, restarted by every start character taken outside backup
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_q <= 1'b0;
            star_q <= 1'b0;
            sum_q <= 8'h00;
            rxck_q <= 8'h00;
            nib_q <= 2'h0;
            fld_q <= 3'h0;
            code_q <= 10'h000;
            arg_q <= 8'h00;
            pat_q <= 5'h00;
            ok_q <= 1'b0;
        end else begin
            ok_q <= 1'b0;
            if (take) begin
                if (rx_data == GPMC_CH_START) begin
                    // Fresh sentence
                    in_q <= 1'b1;
                    star_q <= 1'b0;
                    sum_q <= 8'h00;
                    nib_q <= 2'h0;
                    fld_q <= 3'h0;
                    code_q <= 10'h000;
                    arg_q <= 8'h00;
                    pat_q <= 5'h00;
                end else if (in_q && !star_q) begin
                    // Body: checksum covers every body character
                    if (rx_data == GPMC_CH_STAR) begin
                        star_q <= 1'b1;
                    end else begin
                        sum_q <= sum_q ^ rx_data;
                        if (rx_data == GPMC_CH_COMMA) begin
                            if (fld_q != 3'h7) begin
                                fld_q <= 3'(fld_q + 3'h1);
                            end
                        end else if (is_dig) begin
                            if (fld_q == 3'h0) begin
                                code_q <= 10'(code_q * 10'd10 + {6'h00, dval});
                            end
                            if (fld_q == 3'h1) begin
                                arg_q <= 8'(arg_q * 8'd10 + {4'h0, dval});
                            end
                            if ((fld_q != 3'h0) && (fld_q < 3'h6) && (dval != 4'h0)) begin
                                pat_q[3'(3'h5 - fld_q)] <= 1'b1;
                            end
                        end
                    end
                end else if (in_q) begin
                    // Checksum digits, then line end
                    if (is_hex && (nib_q != 2'h2)) begin
                        rxck_q <= {rxck_q[3:0], hval};
                        nib_q <= 2'(nib_q + 2'h1);
                    end else begin
                        in_q <= 1'b0;
                        ok_q <= ((rx_data == GPMC_CH_CR) || (rx_data == GPMC_CH_LF))
                            && (nib_q == 2'h2) && (rxck_q == sum_q);
                    end
                end
            end else if (state_q == GPMC_BKP) begin
                // Partial sentences do not survive backup
                in_q <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Mode machine
    // ==================================================================
    logic full; // In either full-on sub-state
    logic cmd_stby, cmd_pwr; // Decoded accepted commands
    assign full = (state_q == GPMC_ACQ) || (state_q == GPMC_TRK);
    assign cmd_stby = ok_q && (code_q == GPMC_CMD_STBY) && (arg_q == GPMC_ARG_FULL);
    assign cmd_pwr = ok_q && (code_q == GPMC_CMD_PWR);

    // Next mode
    always_comb begin
        state_d = state_q;
        case (state_q)
            GPMC_ACQ, GPMC_TRK: begin
                // Low-power modes only from full-on
                if (state_q == GPMC_ACQ && acq_done) begin
                    state_d = GPMC_TRK;
                end
                if (stby_fall || cmd_stby) begin
                    state_d = GPMC_STBY;
                end else if (cmd_pwr && !force_sync_q && arg_q == GPMC_ARG_BKP) begin
                    state_d = GPMC_BKP;
                end else if (cmd_pwr && (arg_q == GPMC_ARG_PSTBY
                        || (arg_q == GPMC_ARG_PBKP && !force_sync_q))) begin
                    state_d = GPMC_PER;
                end else if (cmd_pwr && (arg_q == GPMC_ARG_ASTBY
                        || (arg_q == GPMC_ARG_ABKP && !force_sync_q))) begin
                    state_d = GPMC_ADP;
                end
            end
            GPMC_STBY: begin
                // Pin release or any received byte wakes
                if (stby_rise || rx_valid) begin
                    state_d = GPMC_ACQ;
                end
            end
            GPMC_BKP: begin
                // Only the wake pin ends backup
                if (force_sync_q) begin
                    state_d = GPMC_ACQ;
                end
            end
            GPMC_PER, GPMC_ADP: begin
                // Return command at any time
                if (cmd_pwr && arg_q == GPMC_ARG_FULL) begin
                    state_d = GPMC_ACQ;
                end
            end
            default: begin
                state_d = GPMC_ACQ;
            end
        endcase
    end

    // Mode register: power-up lands in full-on acquisition
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= GPMC_ACQ;
        end else begin
            state_q <= state_d;
        end
    end

    // Low-power flavour and constellation choice
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lp_type_periodic_bkp <= 1'b0;
            const_sel <= 2'b11;
        end else begin
            if (full && (state_d == GPMC_PER || state_d == GPMC_ADP)) begin
                lp_type_periodic_bkp <= (arg_q == GPMC_ARG_PBKP) || (arg_q == GPMC_ARG_ABKP);
            end
            if (ok_q && code_q == GPMC_CMD_CONST) begin
                // Unknown patterns leave the choice alone
                case (pat_q)
                    GPMC_PAT_BOTH: const_sel <= 2'b11;
                    GPMC_PAT_FIRST: const_sel <= 2'b10;
                    GPMC_PAT_SECOND: const_sel <= 2'b01;
                    default: const_sel <= const_sel;
                endcase
            end
        end
    end

    // Registered power and engine controls from the next mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_pwr_en <= 1'b1;
            tcxo_en <= 1'b1;
            search_en <= 1'b1;
            nmea_en <= 1'b1;
            uart_en <= 1'b1;
            bkp_switch_open <= 1'b0;
            bkp_mem_hold <= 1'b1;
            hot_start <= 1'b0;
            mode <= 3'h0;
        end else begin
            // Radio, oscillator, search and sentences stop
            rf_pwr_en <= state_d != GPMC_STBY && state_d != GPMC_BKP;
            tcxo_en <= state_d != GPMC_STBY && state_d != GPMC_BKP;
            search_en <= state_d != GPMC_STBY && state_d != GPMC_BKP;
            nmea_en <= state_d != GPMC_STBY && state_d != GPMC_BKP;
            uart_en <= state_d != GPMC_BKP;
            bkp_switch_open <= state_d == GPMC_BKP;
            bkp_mem_hold <= 1'b1;
            // Restart with retained aiding data
            hot_start <= (state_q == GPMC_STBY || state_q == GPMC_BKP)
                && state_d == GPMC_ACQ;
            mode <= 3'(state_d);
        end
    end

    // ==================================================================
    // AHB-Lite register slave
    // ==================================================================
    logic [31:0] cfg_q; // Configuration register
    logic wr_q; // Write data phase pending
    logic [7:0] wadr_q; // Write address
    logic aphase; // Valid address phase

    assign aphase = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address capture and read data, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wadr_q <= 8'h00;
            hrdata <= 32'h00000000;
        end else begin
            wr_q <= aphase && hwrite;
            wadr_q <= haddr[7:0];
            if (aphase && !hwrite) begin
                case (haddr[7:0])
                    GPMC_STATUS_OFS: hrdata <= {24'h000000, lp_type_periodic_bkp,
                        const_sel, bkp_switch_open, 1'b0, mode};
                    GPMC_CONFIG_OFS: hrdata <= cfg_q;
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Configuration: defaults at reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= GPMC_CONFIG_RST;
        end else if (wr_q && wadr_q == GPMC_CONFIG_OFS) begin
            cfg_q <= hwdata;
        end
    end

    // Configuration fields
    assign update_rate = cfg_q[GPMC_RATE_LSB +: 4];
    assign sbas_en = cfg_q[GPMC_SBAS_BIT];
    assign canceller_en = cfg_q[GPMC_CANC_BIT];
    assign logger_en = cfg_q[GPMC_LOG_BIT];
    assign nmea_mask = cfg_q[GPMC_NMEA_LSB +: 6];
    assign baud_rate = cfg_q[GPMC_BAUD_LSB +: 18];
    // Orbit assist gated by update rate
    assign orbit_assist_en = cfg_q[GPMC_ORB_BIT] && (update_rate <= GPMC_RATE_MAX_ORB);

endmodule : gpmc_top

/* testbench/gpmc_properties.sv */
// Checker for the operating-mode controller, bound to its top module
`timescale 1ns/1ps
module gpmc_properties
    import gpmc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Host pins and bytes
    input wire logic stby_req_n,
    input wire logic force_on,
    input wire logic rx_valid,
    // Controls and state
    input wire logic rf_pwr_en,
    input wire logic tcxo_en,
    input wire logic search_en,
    input wire logic nmea_en,
    input wire logic uart_en,
    input wire logic bkp_switch_open,
    input wire logic bkp_mem_hold,
    input wire logic hot_start,
    input wire logic [2:0] mode,
    input wire logic [3:0] update_rate,
    input wire logic orbit_assist_en
);
    // ==========================================================
    // Mode and control relations
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_stby_radio_off: assert property (mode == GPMC_STBY && $past(mode) == GPMC_STBY
        |-> !rf_pwr_en && !tcxo_en && !search_en && !nmea_en && uart_en)
        else $error("standby left radio or sentences on");
    a_bkp_switch_open: assert property (mode == GPMC_BKP
        && $past(mode) == GPMC_BKP |-> bkp_switch_open && !uart_en && !search_en)
        else $error("backup without open switch or with port on");
    a_bkp_mem_held: assert property (bkp_mem_hold)
        else $error("backup memory hold dropped");
    a_orbit_rate_cap: assert property (orbit_assist_en |-> update_rate <= 4'h1)
        else $error("orbit assist on above one hertz");
    a_trk_after_acq: assert property ($changed(mode) && mode == GPMC_TRK
        |-> $past(mode) == GPMC_ACQ)
        else $error("tracking entered not from acquisition");
    a_lp_from_full: assert property ($changed(mode) && mode inside {GPMC_STBY,
        GPMC_BKP, GPMC_PER, GPMC_ADP} |-> $past(mode) inside {GPMC_ACQ, GPMC_TRK})
        else $error("low-power mode entered not from full-on");
    a_bkp_wake_pin: assert property ($changed(mode) && $past(mode) == GPMC_BKP
        |-> $past(force_on) || $past(force_on, 2) || $past(force_on, 3))
        else $error("backup left without wake pin");
    a_hot_one_cycle: assert property (hot_start |=> !hot_start)
        else $error("restart pulse longer than one cycle");
    a_pin_enters_stby: assert property ($fell(stby_req_n)
        && mode inside {GPMC_ACQ, GPMC_TRK} |-> ##[1:4] mode == GPMC_STBY)
        else $error("request pin low did not enter standby");
    a_rx_ends_stby: assert property (rx_valid && stby_req_n && mode == GPMC_STBY
        |-> ##[1:4] mode != GPMC_STBY)
        else $error("received byte did not end standby");
    // Main scenarios reached
    c_backup: cover property (mode == GPMC_BKP);
    c_periodic: cover property (mode == GPMC_PER);
    c_adaptive: cover property (mode == GPMC_ADP);
    c_restart: cover property (hot_start);
endmodule : gpmc_properties

bind gpmc_top gpmc_properties i_gpmc_properties (.hclk(hclk), .hresetn(hresetn),
    .stby_req_n(stby_req_n), .force_on(force_on), .rx_valid(rx_valid),
    .rf_pwr_en(rf_pwr_en), .tcxo_en(tcxo_en), .search_en(search_en), .nmea_en(nmea_en),
    .uart_en(uart_en), .bkp_switch_open(bkp_switch_open), .bkp_mem_hold(bkp_mem_hold),
    .hot_start(hot_start), .mode(mode), .update_rate(update_rate),
    .orbit_assist_en(orbit_assist_en));

/* testbench/gpmc_host_model.sv */
// Host processor model: serial command sentences and control pins
`timescale 1ns/1ps
module gpmc_host_model
    import gpmc_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Serial bytes and pins toward the controller
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic stby_req_n,
    output logic force_on
);
    // ==========================================================
    // Idle levels from time zero
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        stby_req_n = 1'b1;
        force_on = 1'b0;
    end
    // One byte per valid pulse; the line then shows the inverse
    task put_byte(input logic [7:0] b, input int gap);
        @(posedge hclk);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge hclk);
        rx_valid <= 1'b0;
        rx_data <= ~b;
        repeat (gap) @(posedge hclk);
    endtask : put_byte
    // Upper-case hex digit
    function automatic logic [7:0] hex_ch(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction : hex_ch
    // Whole sentence ending in carriage return; bad inverts the checksum
    task send(input string body, input bit bad, input int gap);
        logic [7:0] x;
        x = 8'h00;
        for (int i = 0; i < body.len(); i++) x ^= body[i];
        if (bad) x = ~x;
        put_byte(GPMC_CH_START, gap);
        for (int i = 0; i < body.len(); i++) put_byte(body[i], gap);
        put_byte(GPMC_CH_STAR, gap);
        put_byte(hex_ch(x[7:4]), gap);
        put_byte(hex_ch(x[3:0]), gap);
        put_byte(GPMC_CH_CR, gap);
    endtask : send
    // Pins change just after an edge; wake is kept low before backup requests
    task set_pins(input logic s_n, input logic f);
        @(posedge hclk);
        stby_req_n <= s_n;
        force_on <= f;
    endtask : set_pins
endmodule : gpmc_host_model

/* testbench/gpmc_top_tb.sv */
// Self-checking bench for the operating-mode controller
`timescale 1ns/1ps
module gpmc_top_tb;
    import gpmc_pkg::*;
    // ==========================================================
    // Signals
    logic hclk, hresetn, hsel, hwrite, hready, acq_done, rx_valid, stby_req_n, force_on;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, const_sel;
    logic [2:0] hsize, mode;
    logic [7:0] rx_data;
    logic hreadyout, hresp, rf_pwr_en, tcxo_en, search_en, nmea_en, uart_en, bkp_switch_open;
    logic bkp_mem_hold, hot_start, lp_type_periodic_bkp, sbas_en, canceller_en, logger_en;
    logic orbit_assist_en;
    logic [3:0] update_rate, r;
    logic [5:0] nmea_mask;
    logic [17:0] baud_rate;
    int n_mismatch = 0, tests_run = 0, n_hot = 0, cycles = 0, seed = 41;
    string cs_cmd[3] = '{"353,1,0,0,0,0", "353,0,0,0,0,1", "353,1,0,0,0,1"};
    logic [1:0] cs_exp[3] = '{2'b10, 2'b01, 2'b11};
    string pm_cmd[4] = '{"225,1", "225,2", "225,9", "225,8"};
    logic [2:0] pm_mode[4] = '{GPMC_PER, GPMC_PER, GPMC_ADP, GPMC_ADP};
    logic [3:0] pm_lp = 4'h5;
    assign hready = hreadyout;
    gpmc_top i_gpmc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stby_req_n(stby_req_n),
        .force_on(force_on), .rx_valid(rx_valid), .rx_data(rx_data), .acq_done(acq_done),
        .rf_pwr_en(rf_pwr_en), .tcxo_en(tcxo_en), .search_en(search_en), .nmea_en(nmea_en),
        .uart_en(uart_en), .bkp_switch_open(bkp_switch_open), .bkp_mem_hold(bkp_mem_hold),
        .hot_start(hot_start), .const_sel(const_sel), .mode(mode),
        .lp_type_periodic_bkp(lp_type_periodic_bkp), .update_rate(update_rate),
        .sbas_en(sbas_en), .canceller_en(canceller_en), .logger_en(logger_en),
        .orbit_assist_en(orbit_assist_en), .nmea_mask(nmea_mask), .baud_rate(baud_rate));
    gpmc_host_model i_gpmc_host_model (.hclk(hclk), .rx_valid(rx_valid), .rx_data(rx_data),
        .stby_req_n(stby_req_n), .force_on(force_on));
    // Clock, restart pulse count and hang guard
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (hot_start === 1'b1) n_hot++;
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // ==========================================================
    // Tasks and expectation functions
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Single AHB-Lite word transfer; waits on ready in both phases
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    // Sentence with one random byte spacing of 0 to 2 cycles for all its bytes, then let the mode settle
    task cmd(input string body, input bit bad);
        i_gpmc_host_model.send(body, bad, {$random(seed)} % 3);
        repeat (5) @(posedge hclk);
    endtask : cmd
    function automatic logic [31:0] exp_status(logic lp, logic [1:0] cs, logic bo, logic [2:0] m);
        return {24'h0, lp, cs, bo, 1'b0, m};
    endfunction : exp_status
    function automatic logic exp_orbit(logic [3:0] rate);
        return rate <= GPMC_RATE_MAX_ORB;
    endfunction : exp_orbit
    task end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // ==========================================================
    // Main sequence
    initial begin
        {hsel, hwrite, acq_done, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        hresetn = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({rf_pwr_en, tcxo_en, search_en, nmea_en, uart_en, bkp_switch_open},
            6'h3E);
        chk({nmea_mask, update_rate, sbas_en, canceller_en, logger_en},
            {6'h3F, 4'h1, 3'b110});
        chk({baud_rate, orbit_assist_en, bkp_mem_hold}, {18'd9600, 2'b11});
        ahb(1'b0, 32'(GPMC_CONFIG_OFS), 32'h0);
        chk(rd, GPMC_CONFIG_RST);
        ahb(1'b0, 32'(GPMC_STATUS_OFS), 32'h0);
        chk(rd, exp_status(1'b0, 2'b11, 1'b0, GPMC_ACQ));
        ahb(1'b1, 32'h8, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h8, 32'h0);
        chk(rd, 32'h0);
        chk({hresp, hreadyout}, 2'b01);
        @(posedge hclk) acq_done <= 1'b1;
        @(posedge hclk) acq_done <= 1'b0;
        repeat (4) @(posedge hclk);
        chk(mode, GPMC_TRK);
        for (int i = 0; i < 6; i++) begin
            r = (i < 2) ? 4'(i + 1) : 4'($random(seed));
            ahb(1'b1, 32'(GPMC_CONFIG_OFS), {GPMC_CONFIG_RST[31:4], r});
            ahb(1'b0, 32'(GPMC_CONFIG_OFS), 32'h0);
            chk(rd, {GPMC_CONFIG_RST[31:4], r});
            chk(orbit_assist_en, exp_orbit(r));
        end
        ahb(1'b1, 32'(GPMC_CONFIG_OFS), GPMC_CONFIG_RST);
        cmd("161,0", 1'b1);
        chk(mode, GPMC_TRK);
        cmd("161,0", 1'b0);
        chk({mode, rf_pwr_en, tcxo_en, search_en, nmea_en, uart_en},
            {GPMC_STBY, 5'h01});
        i_gpmc_host_model.put_byte(8'($random(seed)), 0);
        repeat (5) @(posedge hclk);
        chk({mode <= GPMC_TRK, rf_pwr_en, 8'(n_hot)}, {2'b11, 8'h01});
        i_gpmc_host_model.set_pins(1'b0, 1'b0);
        repeat (6) @(posedge hclk);
        chk({mode, nmea_en}, {GPMC_STBY, 1'b0});
        i_gpmc_host_model.set_pins(1'b1, 1'b0);
        repeat (6) @(posedge hclk);
        chk({mode <= GPMC_TRK, nmea_en, 8'(n_hot)}, {2'b11, 8'h02});
        for (int i = 0; i < 3; i++) begin
            cmd(cs_cmd[i], 1'b0);
            chk(const_sel, cs_exp[i]);
        end
        cmd("225,4", 1'b0);
        chk({mode, bkp_switch_open, uart_en, bkp_mem_hold},
            {GPMC_BKP, 3'b101});
        cmd("225,0", 1'b0);
        chk(mode, GPMC_BKP);
        ahb(1'b0, 32'(GPMC_CONFIG_OFS), 32'h0);
        chk(rd, GPMC_CONFIG_RST);
        i_gpmc_host_model.set_pins(1'b1, 1'b1);
        repeat (6) @(posedge hclk);
        chk({mode, bkp_switch_open, 8'(n_hot)}, {GPMC_ACQ, 1'b0, 8'h03});
        i_gpmc_host_model.set_pins(1'b1, 1'b0);
        repeat (4) @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            cmd(pm_cmd[i], 1'b0);
            chk({mode, lp_type_periodic_bkp}, {pm_mode[i], pm_lp[i]});
            cmd("161,0", 1'b0);
            chk(mode, pm_mode[i]);
            cmd("225,0", 1'b0);
            chk(mode <= GPMC_TRK, 1'b1);
        end
        end_of_test();
    end
endmodule : gpmc_top_tb
